/* alarm_dose_control_lines.v */
// Alarm driven control outputs, dose toggle inputs and fixed-rate serial port.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/100ps
//
// Overview of operation
// (RULE1) Control output one follows only port one's alarm logic and output two only port two's.
// (RULE2) With no alarm or pulse a control output is released, which reads as logic high.
// (RULE3) An enabled value alarm with the signal over threshold drives the port output low.
// (RULE4) When the signal falls back below threshold the output is released again.
// (RULE5) Starting integration by key or control input gives a low pulse of 10 to 100 us.
// (RULE6) A dose limit with dose alarm enabled, or a stop by key or input, gives a low pulse of 50 to 200 ms.
// (RULE7) With both alarms enabled the value alarm wins and holds the output low while over threshold.
// (RULE8) A high pulse of at least 200 ms on a port's toggle input toggles that port's integration.
// (RULE9) The serial port runs at a fixed 2400 bit/s with no rate selection.
// (RULE10) The remote party keeps its transmit line marking while the device transmits.
// (RULE11) The serial receiver accepts characters at all times regardless of transmit activity.
// (RULE12) An attached modem auto-answers with result codes off since the device never dials.
// (RULE13) Characters are eight data bits, no parity, one stop bit, both directions.
// (RULE14) Toggle inputs are synchronised and pulses shorter than the minimum are ignored.
`include "alarm_dose_defs.vh"

module alarm_dose_control_lines #(
    parameter CNT_W = 28,
    parameter LONG_PULSE_CYC = (`LONG_PULSE_MS * 1000000) / `CLK_PERIOD_NS,
    parameter TOGGLE_MIN_CYC = (`TOGGLE_MIN_MS * 1000000) / `CLK_PERIOD_NS,
    parameter BAUD_DIV = `CLK_HZ / `SERIAL_BPS
)(
    // Clock, reset, enable
    input wire clock_i,
    input wire rstn_i,
    input wire ce_i,
    // Register port
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output wire [31:0] rdata_o,
    output wire irq_o,
    // Alarm sources per port, bit 0 is port one
    input wire [1:0] value_over_i,
    input wire [1:0] dose_limit_i,
    input wire [1:0] key_toggle_i,
    output wire [1:0] integ_active_o,
    // Control lines
    input wire port_one_dose_toggle_in_i,
    input wire port_two_dose_toggle_in_i,
    output wire port_one_control_out_o,
    output wire port_one_control_out_oe_o,
    output wire port_two_control_out_o,
    output wire port_two_control_out_oe_o,
    // Serial port
    input wire rxd_i,
    output wire txd_o
);

    // Cycle counts are worked out at full width and cut to the counter width on purpose.
    localparam [31:0] SHORT_FULL = (`SHORT_PULSE_US * 1000) / `CLK_PERIOD_NS;
    localparam [31:0] LONG_FULL = LONG_PULSE_CYC;
    localparam [31:0] TOG_FULL = TOGGLE_MIN_CYC;
    localparam [31:0] BAUD_FULL = BAUD_DIV;
    localparam [31:0] HALF_FULL = BAUD_DIV / 2;
    localparam [CNT_W-1:0] SHORT_CYC = SHORT_FULL[CNT_W-1:0];
    localparam [CNT_W-1:0] LONG_CYC = LONG_FULL[CNT_W-1:0];
    localparam [CNT_W-1:0] TOG_CYC = TOG_FULL[CNT_W-1:0];
    localparam [CNT_W-1:0] ONE_CYC = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [15:0] BAUD = BAUD_FULL[15:0];
    localparam [15:0] HALF_BAUD = HALF_FULL[15:0];

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    reg [3:0] ctrl_q;
    reg [`IRQ_W-1:0] irq_stat_q;
    reg [`IRQ_W-1:0] irq_mask_q;
    reg [31:0] rdata_q;
    reg irq_q;
    wire [`IRQ_W-1:0] events;
    wire [1:0] val_en = {ctrl_q[`CTRL_VAL_EN1], ctrl_q[`CTRL_VAL_EN0]};
    wire [1:0] dose_en = {ctrl_q[`CTRL_DOSE_EN1], ctrl_q[`CTRL_DOSE_EN0]};
    reg [1:0] integ_q;
    reg [7:0] rx_data_q;
    reg rx_valid_q;
    wire rx_done;
    wire tx_busy;
    wire tx_done;
    wire tx_start = wr_i && (addr_i == `REG_TX_DATA) && !tx_busy;

    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl_q <= 4'h0;
            irq_stat_q <= {`IRQ_W{1'b0}};
            irq_mask_q <= {`IRQ_W{1'b0}};
            rdata_q <= 32'h0;
            irq_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (wr_i && addr_i == `REG_CTRL)
                ctrl_q <= wdata_i[3:0];
            if (wr_i && addr_i == `REG_IRQ_MASK)
                irq_mask_q <= wdata_i[`IRQ_W-1:0];
            // A new event in the clearing cycle survives the clear.
            if (wr_i && addr_i == `REG_IRQ_STAT)
                irq_stat_q <= (irq_stat_q & ~wdata_i[`IRQ_W-1:0]) | events;
            else
                irq_stat_q <= irq_stat_q | events;
            irq_q <= |(irq_stat_q & irq_mask_q);
            rdata_q <= 32'h0;
            if (rd_i)
            begin
                case (addr_i)
                    `REG_CTRL: rdata_q <= {28'h0, ctrl_q};
                    `REG_STATE: rdata_q <= {26'h0, rx_valid_q, tx_busy, value_over_i, integ_q};
                    `REG_IRQ_STAT: rdata_q <= {24'h0, irq_stat_q};
                    `REG_IRQ_MASK: rdata_q <= {24'h0, irq_mask_q};
                    `REG_RX_DATA: rdata_q <= {24'h0, rx_data_q};
                    default: rdata_q <= 32'h0;
                endcase
            end
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;

    // ----------------------------------------------------------------
    // Per-port dose toggle and control output
    // ----------------------------------------------------------------
    wire [1:0] tog_in = {port_two_dose_toggle_in_i, port_one_dose_toggle_in_i};
    wire [1:0] start_ev;
    wire [1:0] stop_ev;
    wire [1:0] limit_ev;
    reg [1:0] oe_q;
    reg [1:0] od_out_q;

    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1)
        begin : g_port
            reg s1_q;
            reg s2_q;
            reg [CNT_W-1:0] hi_cnt_q;
            reg [CNT_W-1:0] pulse_cnt_q;
            wire in_tog = s2_q && (hi_cnt_q == TOG_CYC - 1'b1); // [RULE14] [RULE8]
            wire tog = in_tog || key_toggle_i[p];
            assign start_ev[p] = tog && !integ_q[p];
            assign stop_ev[p] = tog && integ_q[p];
            assign limit_ev[p] = dose_limit_i[p] && dose_en[p];

            always @(posedge clock_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    hi_cnt_q <= {CNT_W{1'b0}};
                    pulse_cnt_q <= {CNT_W{1'b0}};
                    integ_q[p] <= 1'b0;
                    oe_q[p] <= 1'b0;
                    od_out_q[p] <= 1'b0;
                end
                else if (ce_i)
                begin
                    s1_q <= tog_in[p];
                    s2_q <= s1_q; // [RULE14]
                    // Saturating count fires the toggle once per long pulse.
                    if (!s2_q)
                        hi_cnt_q <= {CNT_W{1'b0}};
                    else if (hi_cnt_q != TOG_CYC)
                        hi_cnt_q <= hi_cnt_q + 1'b1;
                    if (tog)
                        integ_q[p] <= !integ_q[p]; // [RULE8]
                    if (stop_ev[p] || limit_ev[p])
                        pulse_cnt_q <= LONG_CYC; // [RULE6]
                    else if (start_ev[p])
                        pulse_cnt_q <= SHORT_CYC; // [RULE5]
                    else if (pulse_cnt_q != {CNT_W{1'b0}})
                        pulse_cnt_q <= pulse_cnt_q - 1'b1;
                    // Value alarm overrides pulses; idle leaves the line released.
                    if (val_en[p] && value_over_i[p])
                        oe_q[p] <= 1'b1; // [RULE3] [RULE7]
                    else
                        oe_q[p] <= (pulse_cnt_q > ONE_CYC) || start_ev[p] || stop_ev[p] || limit_ev[p]; // [RULE4] [RULE2]
                end
            end
        end
    endgenerate

    // Each pin sees only its own port's drive. [RULE1]
    assign port_one_control_out_o = od_out_q[0];
    assign port_one_control_out_oe_o = oe_q[0];
    assign port_two_control_out_o = od_out_q[1];
    assign port_two_control_out_oe_o = oe_q[1];
    assign integ_active_o = integ_q;

    assign events = {tx_done, rx_done, limit_ev, stop_ev, start_ev};

    // ----------------------------------------------------------------
    // Serial transmitter
    // ----------------------------------------------------------------
    // The rate is a fixed divider; no register can change it. [RULE9]
    reg [15:0] tx_baud_q;
    reg [3:0] tx_bits_q;
    reg [9:0] tx_sh_q;
    reg txd_q;
    assign tx_busy = (tx_bits_q != 4'h0);
    assign tx_done = (tx_bits_q == 4'h1) && (tx_baud_q == 16'h0);

    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_baud_q <= 16'h0;
            tx_bits_q <= 4'h0;
            tx_sh_q <= 10'h3FF;
            txd_q <= 1'b1;
        end
        else if (ce_i)
        begin
            if (tx_start)
            begin
                tx_sh_q <= {1'b1, wdata_i[7:0], 1'b0}; // [RULE13]
                tx_bits_q <= 4'hA;
                tx_baud_q <= BAUD - 1'b1;
                txd_q <= 1'b0;
            end
            else if (tx_busy)
            begin
                if (tx_baud_q == 16'h0)
                begin
                    tx_baud_q <= BAUD - 1'b1;
                    tx_bits_q <= tx_bits_q - 1'b1;
                    tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                    txd_q <= (tx_bits_q == 4'h1) ? 1'b1 : tx_sh_q[1];
                end
                else
                    tx_baud_q <= tx_baud_q - 1'b1;
            end
        end
    end

    assign txd_o = txd_q;

    // ----------------------------------------------------------------
    // Serial receiver
    // ----------------------------------------------------------------
    // Shares nothing with the transmitter, so it listens at all times. [RULE11]
    localparam [1:0] RX_IDLE = 2'h0;
    localparam [1:0] RX_START = 2'h1;
    localparam [1:0] RX_DATA = 2'h2;
    localparam [1:0] RX_STOP = 2'h3;
    reg [1:0] rx_st_q;
    reg [15:0] rx_baud_q;
    reg [2:0] rx_bit_q;
    reg [7:0] rx_sh_q;
    reg rx1_q;
    reg rx2_q;
    reg rx_done_q;
    assign rx_done = rx_done_q;

    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_st_q <= RX_IDLE;
            rx_baud_q <= 16'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h0;
            rx1_q <= 1'b1;
            rx2_q <= 1'b1;
            rx_done_q <= 1'b0;
            rx_data_q <= 8'h0;
            rx_valid_q <= 1'b0;
        end
        else if (ce_i)
        begin
            rx1_q <= rxd_i;
            rx2_q <= rx1_q;
            rx_done_q <= 1'b0;
            if (rx_done_q)
                rx_valid_q <= 1'b1;
            else if (rd_i && addr_i == `REG_RX_DATA)
                rx_valid_q <= 1'b0;
            if (rx_baud_q != 16'h0)
                rx_baud_q <= rx_baud_q - 1'b1;
            case (rx_st_q)
                RX_IDLE:
                    if (!rx2_q)
                    begin
                        rx_st_q <= RX_START;
                        rx_baud_q <= HALF_BAUD;
                    end
                RX_START:
                    if (rx_baud_q == 16'h0)
                    begin
                        rx_st_q <= rx2_q ? RX_IDLE : RX_DATA;
                        rx_baud_q <= BAUD - 1'b1;
                        rx_bit_q <= 3'h0;
                    end
                RX_DATA:
                    if (rx_baud_q == 16'h0)
                    begin
                        rx_sh_q <= {rx2_q, rx_sh_q[7:1]}; // [RULE13]
                        rx_baud_q <= BAUD - 1'b1;
                        rx_bit_q <= rx_bit_q + 1'b1;
                        if (rx_bit_q == 3'h7)
                            rx_st_q <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_baud_q == 16'h0)
                    begin
                        // A bad stop bit drops the character.
                        if (rx2_q)
                        begin
                            rx_data_q <= rx_sh_q;
                            rx_done_q <= 1'b1;
                        end
                        rx_st_q <= RX_IDLE;
                    end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

endmodule

/* alarm_dose_defs.vh */
// Constants for the alarm and dose control line block.
`ifndef ALARM_DOSE_DEFS_VH
`define ALARM_DOSE_DEFS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define SHORT_PULSE_US 20
`define LONG_PULSE_MS 100
`define TOGGLE_MIN_MS 200
`define SERIAL_BPS 2400
`define CLK_HZ 50000000

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATE 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0C
`define REG_TX_DATA 8'h10
`define REG_RX_DATA 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_VAL_EN0 0
`define CTRL_DOSE_EN0 1
`define CTRL_VAL_EN1 2
`define CTRL_DOSE_EN1 3
`define ST_TX_BUSY 4
`define ST_RX_VALID 5
`define EV_START 0
`define EV_STOP 2
`define EV_LIMIT 4
`define EV_RX 6
`define EV_TX 7
`define IRQ_W 8

`endif

/* alarm_dose_sva.sv */
// Port-level checks for the alarm and dose control line block.
`timescale 1ns/100ps
module alarm_dose_sva #(
    parameter TOGGLE_MIN_CYC = 10000000,
    parameter BAUD_DIV = 20833
)(
    input wire clock_i,
    input wire rstn_i,
    input wire ce_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [31:0] rdata_o,
    input wire [1:0] value_over_i,
    input wire [1:0] dose_limit_i,
    input wire [1:0] key_toggle_i,
    input wire [1:0] integ_active_o,
    input wire port_one_dose_toggle_in_i,
    input wire port_one_control_out_oe_o,
    input wire port_two_control_out_oe_o,
    input wire txd_o
);
    logic [3:0] ctrl_q;
    logic [31:0] high_q;
    logic [31:0] tx_q;
    wire tx_go = ce_i && wr_i && addr_i == 8'h10 && tx_q == 32'h0;
    // The enables live inside the block, so they are mirrored from the register writes.
    always @(posedge clock_i or negedge rstn_i)
        ctrl_q <= !rstn_i ? 4'h0 : (ce_i && wr_i && addr_i == 8'h00) ? wdata_i[3:0] : ctrl_q;
    always @(posedge clock_i or negedge rstn_i)
        high_q <= (!rstn_i || !port_one_dose_toggle_in_i) ? 32'h0 : high_q + 32'h1;
    always @(posedge clock_i or negedge rstn_i)
        tx_q <= !rstn_i ? 32'h0 : tx_go ? 32'h1 : (tx_q == 32'h0 || tx_q == 10 * BAUD_DIV) ? 32'h0 : tx_q + 32'h1;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    sequence start_one;
        ce_i && key_toggle_i[0] && !integ_active_o[0];
    endsequence
    sequence stop_one;
        ce_i && key_toggle_i[0] && integ_active_o[0];
    endsequence
    value_one_a: assert property (ctrl_q[0] && value_over_i[0] && ce_i |=> port_one_control_out_oe_o)
        else $error("port one not held by value alarm");
    value_two_a: assert property (ctrl_q[2] && value_over_i[1] && ce_i |=> port_two_control_out_oe_o)
        else $error("port two not held by value alarm");
    oe_cause_a: assert property ($rose(port_one_control_out_oe_o) |-> $past(ctrl_q[0] && value_over_i[0])
        || $changed(integ_active_o[0]) || $past(ctrl_q[1] && dose_limit_i[0])) else $error("port one low uncaused");
    start_pulse_a: assert property (start_one |=> integ_active_o[0] && port_one_control_out_oe_o)
        else $error("no start pulse");
    stop_pulse_a: assert property (stop_one |=> !integ_active_o[0] ##0 port_one_control_out_oe_o[*8])
        else $error("no stop pulse");
    dose_pulse_a: assert property (ctrl_q[1] && dose_limit_i[0] && ce_i |=> port_one_control_out_oe_o[*8])
        else $error("no dose limit pulse");
    toggle_min_a: assert property ($changed(integ_active_o[0]) && !$past(key_toggle_i[0])
        |-> high_q >= TOGGLE_MIN_CYC) else $error("toggle on short pulse");
    tx_start_a: assert property (tx_go |=> !txd_o) else $error("no start bit");
    tx_rate_a: assert property ($changed(txd_o) && tx_q != 32'h0 |-> (tx_q - 32'h1) % BAUD_DIV == 0)
        else $error("serial bit off rate");
    rd_idle_a: assert property (!$past(rd_i && ce_i) |-> rdata_o == 32'h0) else $error("read data outside slot");
endmodule
bind alarm_dose_control_lines alarm_dose_sva #(.TOGGLE_MIN_CYC(TOGGLE_MIN_CYC), .BAUD_DIV(BAUD_DIV)) i_alarm_dose_sva (.*);

/* serial_terminal.sv */
// Serial terminal model on the far side of the serial port.
`timescale 1ns/100ps
module serial_terminal #(
    parameter BAUD_DIV = 16
)(
    input wire clock_i,
    input wire txd_i,
    output logic rxd_o
);
    logic [7:0] got;
    // Only answers, never dials; keeps its line marking unless it sends.
    initial rxd_o = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clock_i);
            rxd_o <= f[i];
            repeat (BAUD_DIV - 1) @(posedge clock_i);
        end
    endtask
    always
    begin
        @(negedge txd_i);
        repeat (BAUD_DIV / 2) @(posedge clock_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BAUD_DIV) @(posedge clock_i);
            got[i] = txd_i;
        end
    end
endmodule

/* tb_alarm_dose_control_lines.sv */
// Self-checking testbench for the alarm and dose control line block.
`timescale 1ns/100ps
`include "alarm_dose_defs.vh"
module tb_alarm_dose_control_lines;
    localparam LONG = 1200;
    localparam TMIN = 300;
    localparam BAUD = 16;
    logic clock_i, rstn_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, tog1 = 1'b0, tog2 = 1'b0, rxd;
    logic irq_o, out1, oe1, out2, oe2, txd;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, d;
    logic [1:0] value_over_i = 2'h0, dose_limit_i = 2'h0, key_toggle_i = 2'h0, integ_active_o;
    int n_errors = 0;
    int n_checks = 0;
    int n;
    alarm_dose_control_lines #(.LONG_PULSE_CYC(LONG), .TOGGLE_MIN_CYC(TMIN), .BAUD_DIV(BAUD)) i_alarm_dose_control_lines (
        .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .value_over_i(value_over_i), .dose_limit_i(dose_limit_i),
        .key_toggle_i(key_toggle_i), .integ_active_o(integ_active_o), .port_one_dose_toggle_in_i(tog1),
        .port_two_dose_toggle_in_i(tog2), .port_one_control_out_o(out1), .port_one_control_out_oe_o(oe1),
        .port_two_control_out_o(out2), .port_two_control_out_oe_o(oe2), .rxd_i(rxd), .txd_o(txd));
    serial_terminal #(.BAUD_DIV(BAUD)) i_serial_terminal (.clock_i(clock_i), .txd_i(txd), .rxd_o(rxd));
    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    task print_verdict;
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_i);
        {addr_i, wdata_i, wr_i} <= {a, v, 1'b1};
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clock_i);
        {addr_i, rd_i} <= {a, 1'b1};
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task strobe(input logic [1:0] k, input logic [1:0] v, input logic [1:0] dl);
        @(posedge clock_i);
        {key_toggle_i, value_over_i, dose_limit_i} <= {k, v, dl};
        @(posedge clock_i);
        {key_toggle_i, dose_limit_i} <= 4'h0;
        tick(2);
    endtask
    task hold(input logic [1:0] p, input int k);
        @(posedge clock_i);
        {tog2, tog1} <= p;
        repeat (k) @(posedge clock_i);
        {tog2, tog1} <= 2'h0;
        tick(3);
    endtask
    // Measures how long a port one pulse still stands, bounded in case it never ends.
    task plen;
        for (n = 2; oe1 !== 1'b0 && n < 9000; n++)
            tick(1);
    endtask
    task t_value;
        wr(`REG_CTRL, 32'h1);
        strobe(2'h0, 2'h3, 2'h0);
        chk({oe1, oe2, out1, out2}, 32'h8);
        rd(`REG_STATE);
        chk(d, 32'hC);
        wr(`REG_CTRL, 32'h4);
        tick(3);
        chk({oe1, oe2}, 32'h1);
        strobe(2'h0, 2'h0, 2'h0);
        chk({oe1, oe2}, 32'h0);
    endtask
    task t_key;
        wr(`REG_IRQ_MASK, 32'h1);
        strobe(2'h1, 2'h0, 2'h0);
        chk(integ_active_o, 32'h1);
        plen;
        chk(n >= 500 && n <= 5000, 32'h1);
        chk(irq_o, 32'h1);
        wr(`REG_IRQ_STAT, 32'h1);
        tick(3);
        chk(irq_o, 32'h0);
        strobe(2'h1, 2'h0, 2'h0);
        chk(integ_active_o, 32'h0);
        plen;
        chk(n >= LONG - 3 && n <= LONG + 3, 32'h1);
        rd(`REG_IRQ_STAT);
        chk({irq_o, d[30:0]}, 32'h4);
        wr(`REG_IRQ_STAT, 32'hFF);
    endtask
    task t_dose;
        strobe(2'h0, 2'h0, 2'h1);
        chk(oe1, 32'h0);
        wr(`REG_CTRL, 32'h3);
        strobe(2'h0, 2'h0, 2'h1);
        plen;
        chk(n >= LONG - 3 && n <= LONG + 3, 32'h1);
        strobe(2'h0, 2'h1, 2'h1);
        tick(LONG + 50);
        chk(oe1, 32'h1);
        strobe(2'h0, 2'h0, 2'h0);
        chk(oe1, 32'h0);
        rd(`REG_IRQ_STAT);
        chk(d, 32'h10);
        wr(`REG_IRQ_STAT, 32'hFF);
        wr(`REG_CTRL, 32'h0);
    endtask
    task t_toggle;
        hold(2'h1, 100);
        chk(integ_active_o, 32'h0);
        hold(2'h1, TMIN + 20);
        chk(integ_active_o, 32'h1);
        hold(2'h2, TMIN + 20);
        chk(integ_active_o, 32'h3);
        hold(2'h3, TMIN + 20);
        chk(integ_active_o, 32'h0);
        tick(LONG + 50);
        chk({oe1, oe2}, 32'h0);
    endtask
    // Key strobes while the enable is low must leave integration and both control outputs untouched.
    task t_freeze;
        @(posedge clock_i);
        ce_i <= 1'b0;
        strobe(2'h3, 2'h0, 2'h0);
        chk({integ_active_o, oe1, oe2}, 32'h0);
        @(posedge clock_i);
        ce_i <= 1'b1;
    endtask
    task t_serial;
        wr(`REG_IRQ_STAT, 32'hFF);
        wr(`REG_IRQ_MASK, 32'h40);
        wr(`REG_TX_DATA, 32'hA5);
        // A second write while the frame is still going out must be dropped.
        wr(`REG_TX_DATA, 32'h5A);
        tick(11 * BAUD);
        chk(i_serial_terminal.got, 32'hA5);
        i_serial_terminal.send(8'h3C);
        tick(2 * BAUD);
        rd(`REG_STATE);
        chk({irq_o, d[30:0]}, 32'h80000020);
        rd(`REG_RX_DATA);
        chk(d, 32'h3C);
        rd(`REG_IRQ_STAT);
        chk(d, 32'hC0);
    endtask
    initial
    begin
        repeat (12) @(posedge clock_i);
        rstn_i <= 1'b1;
        tick(1);
        chk({oe1, oe2, out1, out2, txd, irq_o, integ_active_o}, 32'h8);
        rd(8'h18);
        chk(d, 32'h0);
        t_value;
        t_key;
        t_dose;
        t_toggle;
        t_freeze;
        t_serial;
        print_verdict;
    end
    initial
    begin
        repeat (40000) @(posedge clock_i);
        n_errors++;
        print_verdict;
    end
endmodule
